// File: dv/mfd_partner.sv
// partner model: client pause requester, transmitter ack and received pause frames
`timescale 1ns/1ps
module mfd_partner (
  // clock
  input  wire logic        clk,
  // receive side
  output logic             rx_ctrl_frame,
  output logic      [15:0] rx_pause_quanta,
  // transmit side
  output logic             client_pause_request,
  input  wire logic        pause_send_req,
  output logic             pause_send_ack
);
  int ack_delay = 0;
  int wait_cnt  = 0;
  int n_sent    = 0;

  initial begin
    rx_ctrl_frame        = 1'b0;
    rx_pause_quanta      = 16'hA5A5;
    client_pause_request = 1'b0;
    pause_send_ack       = 1'b0;
  end

  // transmitter takes the pause frame after ack_delay cycles, prompt or slow
  always @(posedge clk) begin
    pause_send_ack <= 1'b0;
    if (pause_send_req === 1'b1 && !pause_send_ack) begin
      if (wait_cnt >= ack_delay) begin
        pause_send_ack <= 1'b1;
        n_sent         <= n_sent + 1;
        wait_cnt       <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end

  task automatic frame(input logic [15:0] q);
    rx_ctrl_frame   <= 1'b1;
    rx_pause_quanta <= q;
    @(posedge clk);
    rx_ctrl_frame   <= 1'b0;
    // stale quanta must never look like the last value
    rx_pause_quanta <= ~q;
  endtask

  // request held past the ack, then dropped so a new one can follow
  task automatic ask_pause();
    client_pause_request <= 1'b1;
    repeat (12) @(posedge clk);
    client_pause_request <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// File: dv/mfd_top_bench.sv
// self-checking bench of the MAC default-control block
`timescale 1ns/1ps
`include "mfd_regs.svh"
module mfd_top_bench;
  logic        clk;
  logic        nrst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        filter_enable;
  logic        tx_reset;
  logic        tx_half_duplex;
  logic        rx_ctrl_frame;
  logic [15:0] rx_pause_quanta;
  logic        rx_ctrl_forward;
  logic        tx_inhibit;
  logic        client_pause_request;
  logic        pause_send_req;
  logic        pause_send_ack;
  logic        filter_enable_fixed;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n_fwd = 0;
  int          sent0;
  logic [31:0] rnd;
  logic [31:0] exp_q[$];

  mfd_top #(.quantum_cycles(1)) dut (
    .clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .filter_enable(filter_enable), .tx_reset(tx_reset), .tx_half_duplex(tx_half_duplex),
    .rx_ctrl_frame(rx_ctrl_frame), .rx_pause_quanta(rx_pause_quanta),
    .rx_ctrl_forward(rx_ctrl_forward), .tx_inhibit(tx_inhibit),
    .client_pause_request(client_pause_request), .pause_send_req(pause_send_req),
    .pause_send_ack(pause_send_ack)
  );

  // no management port: writes dropped, filter stays at its default
  mfd_top #(
    .management_port_present (1'b0),
    .filter_default_on       (1'b0),
    .rx_pause_honor_default  (1'b0),
    .tx_pause_send_default   (1'b0),
    .quantum_cycles          (1)
  ) dut_fixed (
    .clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(), .avs_waitrequest(),
    .filter_enable(filter_enable_fixed), .tx_reset(), .tx_half_duplex(),
    .rx_ctrl_frame(rx_ctrl_frame), .rx_pause_quanta(rx_pause_quanta),
    .rx_ctrl_forward(), .tx_inhibit(),
    .client_pause_request(client_pause_request), .pause_send_req(),
    .pause_send_ack(pause_send_ack)
  );

  mfd_partner partner (
    .clk(clk), .rx_ctrl_frame(rx_ctrl_frame), .rx_pause_quanta(rx_pause_quanta),
    .client_pause_request(client_pause_request), .pause_send_req(pause_send_req),
    .pause_send_ack(pause_send_ack)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // read results are judged here as they appear
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_ctrl_forward === 1'b1) n_fwd <= n_fwd + 1;
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk(avs_readdata, 32'hFFFF_FFFF);
      else chk(avs_readdata, exp_q.pop_front());
    end
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic rx_case(input logic [15:0] q, input logic inh, input int fwd);
    partner.frame(q);
    @(negedge clk);
    chk({31'h0, tx_inhibit}, {31'h0, inh});
    repeat (8) @(negedge clk);
    chk({31'h0, tx_inhibit}, 32'h0000_0000);
    chk(n_fwd, fwd);
    @(posedge clk);
  endtask

  task automatic tx_case(input int ad, input int more);
    partner.ack_delay = ad;
    sent0 = partner.n_sent;
    partner.ask_pause();
    chk(partner.n_sent - sent0, more);
  endtask

  initial begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    void'($urandom(32'hBC6C));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({29'h0, filter_enable, tx_reset, tx_half_duplex}, 32'h0000_0004);
    chk({31'h0, filter_enable_fixed}, 32'h0000_0000);
    rd(`MFD_OFF_STATUS, 32'h0000_0004);
    rd(`MFD_OFF_FILTER, 32'h0000_0001);
    rd(`MFD_OFF_FLOW, 32'h0000_0003);
    rd(4'h2, `MFD_READ_UNMAPPED);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      bus(1'b1, `MFD_OFF_FILTER, rnd);
      chk({31'h0, filter_enable}, {31'h0, rnd[0]});
      chk({31'h0, filter_enable_fixed}, 32'h0000_0000);
      rd(`MFD_OFF_FILTER, {31'h0, rnd[0]});
    end
    $display("test filter done");
    rx_case(16'($urandom_range(1, 4)), 1'b1, 0);
    tx_case(0, 1);
    tx_case(5, 1);
    $display("test flow on done");
    bus(1'b1, `MFD_OFF_FLOW, 32'h0000_0002);
    rx_case(16'h0003, 1'b0, 1);
    bus(1'b1, `MFD_OFF_FLOW, 32'h0000_0001);
    tx_case(0, 0);
    rd(`MFD_OFF_FLOW, 32'h0000_0001);
    $display("test flow off done");
    bus(1'b1, `MFD_OFF_FLOW, 32'h0000_0003);
    bus(1'b1, `MFD_OFF_TXCFG, 32'h0000_0002);
    chk({31'h0, tx_half_duplex}, 32'h0000_0001);
    rd(`MFD_OFF_STATUS, 32'h0000_0000);
    rx_case(16'h0003, 1'b0, 2);
    tx_case(0, 0);
    $display("test half duplex done");
    bus(1'b1, `MFD_OFF_TXCFG, 32'h0000_0003);
    chk({30'h0, tx_reset, tx_half_duplex}, 32'h0000_0002);
    rd(`MFD_OFF_TXCFG, 32'h0000_0001);
    rd(`MFD_OFF_STATUS, 32'h0000_0004);
    tx_case(0, 0);
    $display("test tx reset done");
    wrap_up();
  end
endmodule

// File: shared/mfd_flow_if.sv
// configuration and status passed between register file and flow-control engine
`timescale 1ns/1ps
interface mfd_flow_if;
  logic rx_honor_en;
  logic tx_send_en;
  logic full_duplex;
  logic tx_in_reset;
  logic inhibit;
  logic send_busy;

  modport cfg  (output rx_honor_en, output tx_send_en, output full_duplex,
                output tx_in_reset, input inhibit, input send_busy);
  modport flow (input rx_honor_en, input tx_send_en, input full_duplex,
                input tx_in_reset, output inhibit, output send_busy);
endinterface

// File: shared/mfd_pkg.sv
// types shared by the MAC default-control modules
package mfd_pkg;

  typedef enum logic [2:0] {
    mfd_reg_filter = 3'h0,
    mfd_reg_flow   = 3'h1,
    mfd_reg_txcfg  = 3'h2,
    mfd_reg_status = 3'h3,
    mfd_reg_none   = 3'h4
  } mfd_reg_t;

  // gray along idle -> send -> hold
  typedef enum logic [1:0] {
    mfd_tx_idle = 2'h0,
    mfd_tx_send = 2'h1,
    mfd_tx_hold = 2'h3
  } mfd_tx_state_t;

  typedef struct packed {
    logic        served;
    logic [31:0] readdata;
    logic        filter_on;
    logic        rx_honor;
    logic        tx_send;
    logic        tx_rst;
    logic        half_dup;
  } mfd_top_state_t;

  typedef struct packed {
    logic [15:0]   pause_cnt;
    logic [15:0]   tick_cnt;
    logic          fwd;
    logic          req_prev;
    mfd_tx_state_t tx_state;
  } mfd_flow_state_t;

endpackage

// File: shared/mfd_regs.svh
// register offsets, field positions and timing counts of the MAC default-control block
`ifndef MFD_REGS_SVH
`define MFD_REGS_SVH

`define MFD_OFF_FILTER      4'h0
`define MFD_OFF_FLOW        4'h4
`define MFD_OFF_TXCFG       4'h8
`define MFD_OFF_STATUS      4'hC

`define MFD_BIT_FILTER_ON   0
`define MFD_BIT_RX_HONOR    0
`define MFD_BIT_TX_SEND     1
`define MFD_BIT_TX_RESET    0
`define MFD_BIT_HALF_DUPLEX 1
`define MFD_BIT_INHIBIT     0
`define MFD_BIT_SEND_BUSY   1
`define MFD_BIT_FULL_DUPLEX 2

`define MFD_READ_UNMAPPED   32'h0000_0000
`define MFD_QUANTUM_CYCLES  16

`endif

// File: src/mfd_flow.sv
// pause honouring on receive and pause-frame requests on transmit
`timescale 1ns/1ps
`include "mfd_regs.svh"
module mfd_flow #(
  parameter int quantum_cycles = `MFD_QUANTUM_CYCLES
) (
  // clock and synchronised reset
  input  wire logic        clk,
  input  wire logic        nrst_sync,
  // configuration
  mfd_flow_if.flow         fl,
  // receive side
  input  wire logic        rx_ctrl_frame,
  input  wire logic [15:0] rx_pause_quanta,
  output logic             rx_ctrl_forward,
  output logic             tx_inhibit,
  // transmit side
  input  wire logic        client_pause_request,
  output logic             pause_send_req,
  input  wire logic        pause_send_ack
);

  if (quantum_cycles < 1 || quantum_cycles > 65535) begin : g_chk
    $error("quantum_cycles out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(quantum_cycles - 1);

  mfd_pkg::mfd_flow_state_t st;
  mfd_pkg::mfd_flow_state_t next_st;
  logic rx_active;
  logic tx_active;

  // half duplex disables both directions; transmitter reset disables only the transmit side
  assign rx_active = fl.rx_honor_en & fl.full_duplex;
  assign tx_active = fl.tx_send_en & fl.full_duplex & ~fl.tx_in_reset;

  always_comb begin
    next_st = st;
    next_st.req_prev = client_pause_request;
    next_st.fwd = rx_ctrl_frame & ~rx_active;
    if (st.pause_cnt != 16'h0) begin
      if (st.tick_cnt == TICK_LAST) begin
        next_st.tick_cnt = 16'h0;
        next_st.pause_cnt = st.pause_cnt - 16'h1;
      end else begin
        next_st.tick_cnt = st.tick_cnt + 16'h1;
      end
    end
    if (rx_ctrl_frame & rx_active) begin
      next_st.pause_cnt = rx_pause_quanta;
      next_st.tick_cnt = 16'h0;
    end
    if (!fl.full_duplex) begin
      next_st.pause_cnt = 16'h0;
    end
    case (st.tx_state)
      mfd_pkg::mfd_tx_idle: begin
        if (client_pause_request & ~st.req_prev & tx_active) begin
          next_st.tx_state = mfd_pkg::mfd_tx_send;
        end
      end
      mfd_pkg::mfd_tx_send: begin
        if (!tx_active) begin
          next_st.tx_state = mfd_pkg::mfd_tx_idle;
        end else if (pause_send_ack) begin
          next_st.tx_state = mfd_pkg::mfd_tx_hold;
        end
      end
      mfd_pkg::mfd_tx_hold: begin
        // one frame per request; wait for the client to let go
        if (!client_pause_request) begin
          next_st.tx_state = mfd_pkg::mfd_tx_idle;
        end
      end
      default: begin
        next_st.tx_state = mfd_pkg::mfd_tx_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rx_ctrl_forward = st.fwd;
  assign tx_inhibit      = st.pause_cnt != 16'h0;
  assign pause_send_req  = st.tx_state == mfd_pkg::mfd_tx_send;
  assign fl.inhibit      = tx_inhibit;
  assign fl.send_busy    = pause_send_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst_sync);

  a_rx_honor: assert property (
    rx_ctrl_frame && fl.rx_honor_en && fl.full_duplex && rx_pause_quanta != 16'h0
    |=> tx_inhibit && !rx_ctrl_forward)
    else $error("honoured pause frame did not inhibit transmitter");
  a_rx_forward: assert property (
    rx_ctrl_frame && !fl.rx_honor_en |=> rx_ctrl_forward && !$rose(tx_inhibit))
    else $error("pause frame not forwarded while receive flow control off");
  a_half_inert: assert property (
    !fl.full_duplex |=> !tx_inhibit && !pause_send_req)
    else $error("flow control active in half duplex");
  a_half_forward: assert property (
    rx_ctrl_frame && !fl.full_duplex |=> rx_ctrl_forward)
    else $error("half duplex pause frame not forwarded");
  a_pause_send: assert property (
    tx_active && client_pause_request && !st.req_prev
    && st.tx_state == mfd_pkg::mfd_tx_idle |=> pause_send_req)
    else $error("pause request did not start a pause frame");
  a_pause_ignore: assert property (
    !fl.tx_send_en |=> !pause_send_req)
    else $error("pause frame requested while transmit flow control off");

endmodule

// File: src/mfd_top.sv
// register file and defaults for address filter, flow control and transmitter reset
// How it works
// - with management port present, software toggles the address filter by register write.
// - without management port, filter mode stays at its static default.
// - filter default option sets reset value of filter-on bit; true enables filtering.
// - receive flow control on in full duplex: pause frames inhibit transmitter, not forwarded.
// - receive flow control off: pause frames go to client and do not pause the transmitter.
// - transmit flow control on in full duplex, transmitter out of reset: client request produces one pause frame.
// - transmit flow control off: client pause requests are ignored.
// - transmitter reset bit holds transmitter reset and restores its configuration defaults.
// - static options give reset values of both flow enables; software may overwrite only with management port present.
// - half-duplex bit set selects half duplex, clear selects full duplex.
`timescale 1ns/1ps
`include "mfd_regs.svh"
module mfd_top #(
  parameter bit management_port_present   = 1'b1,
  parameter bit filter_default_on         = 1'b1,
  parameter bit rx_pause_honor_default    = 1'b1,
  parameter bit tx_pause_send_default     = 1'b1,
  parameter bit transmitter_reset_default = 1'b0,
  parameter bit tx_half_duplex_default    = 1'b0,
  parameter int quantum_cycles            = `MFD_QUANTUM_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // configuration outputs
  output logic             filter_enable,
  output logic             tx_reset,
  output logic             tx_half_duplex,
  // receive side
  input  wire logic        rx_ctrl_frame,
  input  wire logic [15:0] rx_pause_quanta,
  output logic             rx_ctrl_forward,
  output logic             tx_inhibit,
  // transmit side
  input  wire logic        client_pause_request,
  output logic             pause_send_req,
  input  wire logic        pause_send_ack
);

  mfd_pkg::mfd_top_state_t st;
  mfd_pkg::mfd_top_state_t next_st;
  logic [1:0]              rst_pipe;
  logic                    nrst_sync;
  logic                    req;
  mfd_pkg::mfd_reg_t       sel;
  mfd_flow_if              fl ();

  function automatic mfd_pkg::mfd_reg_t decode(input logic [3:0] a);
    case (a)
      `MFD_OFF_FILTER: decode = mfd_pkg::mfd_reg_filter;
      `MFD_OFF_FLOW:   decode = mfd_pkg::mfd_reg_flow;
      `MFD_OFF_TXCFG:  decode = mfd_pkg::mfd_reg_txcfg;
      `MFD_OFF_STATUS: decode = mfd_pkg::mfd_reg_status;
      default:         decode = mfd_pkg::mfd_reg_none;
    endcase
  endfunction

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign nrst_sync = rst_pipe[1];

  assign req = avs_read | avs_write;
  assign sel = decode(avs_address);

  always_comb begin
    next_st = st;
    // one wait cycle per access; read data latched in that cycle
    next_st.served = req & ~st.served;
    if (req && !st.served) begin
      next_st.readdata = 32'h0000_0000;
      case (sel)
        mfd_pkg::mfd_reg_filter: begin
          next_st.readdata[`MFD_BIT_FILTER_ON] = st.filter_on;
        end
        mfd_pkg::mfd_reg_flow: begin
          next_st.readdata[`MFD_BIT_RX_HONOR] = st.rx_honor;
          next_st.readdata[`MFD_BIT_TX_SEND]  = st.tx_send;
        end
        mfd_pkg::mfd_reg_txcfg: begin
          next_st.readdata[`MFD_BIT_TX_RESET]    = st.tx_rst;
          next_st.readdata[`MFD_BIT_HALF_DUPLEX] = st.half_dup;
        end
        mfd_pkg::mfd_reg_status: begin
          next_st.readdata[`MFD_BIT_INHIBIT]     = fl.inhibit;
          next_st.readdata[`MFD_BIT_SEND_BUSY]   = fl.send_busy;
          next_st.readdata[`MFD_BIT_FULL_DUPLEX] = fl.full_duplex;
        end
        default: begin
          next_st.readdata = `MFD_READ_UNMAPPED;
        end
      endcase
    end
    // writes are accepted but dropped when no management port exists
    if (avs_write && st.served && management_port_present) begin
      case (sel)
        mfd_pkg::mfd_reg_filter: begin
          next_st.filter_on = avs_writedata[`MFD_BIT_FILTER_ON];
        end
        mfd_pkg::mfd_reg_flow: begin
          next_st.rx_honor = avs_writedata[`MFD_BIT_RX_HONOR];
          next_st.tx_send  = avs_writedata[`MFD_BIT_TX_SEND];
        end
        mfd_pkg::mfd_reg_txcfg: begin
          next_st.tx_rst   = avs_writedata[`MFD_BIT_TX_RESET];
          next_st.half_dup = avs_writedata[`MFD_BIT_HALF_DUPLEX];
        end
        default: begin
          next_st.served = 1'b0;
        end
      endcase
    end
    // reset bit itself stays so software can release the transmitter
    if (next_st.tx_rst) begin
      next_st.half_dup = tx_half_duplex_default;
    end
  end

  always_ff @(posedge clk or negedge nrst_sync) begin
    if (!nrst_sync) begin
      st.served    <= 1'b0;
      st.readdata  <= 32'h0000_0000;
      st.filter_on <= filter_default_on;
      st.rx_honor  <= rx_pause_honor_default;
      st.tx_send   <= tx_pause_send_default;
      st.tx_rst    <= transmitter_reset_default;
      st.half_dup  <= tx_half_duplex_default;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata    = st.readdata;
  assign avs_waitrequest = ~st.served;
  assign filter_enable   = st.filter_on;
  assign tx_reset        = st.tx_rst;
  assign tx_half_duplex  = st.half_dup;

  assign fl.rx_honor_en = st.rx_honor;
  assign fl.tx_send_en  = st.tx_send;
  assign fl.full_duplex = ~st.half_dup;
  assign fl.tx_in_reset = st.tx_rst;

  mfd_flow #(
    .quantum_cycles (quantum_cycles)
  ) u_flow (
    .clk                  (clk),
    .nrst_sync            (nrst_sync),
    .fl                   (fl.flow),
    .rx_ctrl_frame        (rx_ctrl_frame),
    .rx_pause_quanta      (rx_pause_quanta),
    .rx_ctrl_forward      (rx_ctrl_forward),
    .tx_inhibit           (tx_inhibit),
    .client_pause_request (client_pause_request),
    .pause_send_req       (pause_send_req),
    .pause_send_ack       (pause_send_ack)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst_sync);

  a_filter_write: assert property (
    management_port_present && avs_write && !avs_waitrequest
    && sel == mfd_pkg::mfd_reg_filter
    |=> filter_enable == $past(avs_writedata[`MFD_BIT_FILTER_ON]))
    else $error("filter mode write not applied");
  a_filter_fixed: assert property (
    !management_port_present |-> filter_enable == filter_default_on)
    else $error("filter mode changed without management port");
  a_filter_default: assert property (
    $rose(nrst_sync) |-> filter_enable == filter_default_on)
    else $error("filter mode reset value wrong");
  a_flow_default: assert property (
    $rose(nrst_sync) |-> fl.rx_honor_en == rx_pause_honor_default
    && fl.tx_send_en == tx_pause_send_default)
    else $error("flow control reset values wrong");
  // a pause frame already pending drains one cycle after the reset bit lands
  a_txrst_default: assert property (
    tx_reset |-> (tx_half_duplex == tx_half_duplex_default) ##1 !pause_send_req)
    else $error("transmitter configuration not held at default in reset");
  a_duplex_map: assert property (
    tx_half_duplex |=> !tx_inhibit)
    else $error("half duplex did not disable receive flow control");
  a_bus_answer: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");

endmodule
